//--- sbs_cycle_decode.sv
/*
 Cycle decode, burst counter, byte-lane strobes and data pin control
 of a pipelined synchronous burst SRAM. Core array sits outside and
 consumes the write stream; read data returns on core_rd_data_in.
 Bus inputs are synchronous to clk_in; sleep and mode are asynchronous.
*/
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_cycle_decode #(
	parameter int  LANES        = 4,
	parameter int  ADDR_W       = 19,
	parameter bit  THREE_SELECT = 1'b1
) (
	// Clock and reset
	input  wire logic                       clk_in,
	input  wire logic                       nrst_in,
	// Selects and strobes
	input  wire logic                       sleep_request_in,
	input  wire logic                       chip_select_primary_n_in,
	input  wire logic                       chip_select_positive_in,
	input  wire logic                       chip_select_secondary_n_in,
	input  wire logic                       proc_addr_strobe_n_in,
	input  wire logic                       ctrl_addr_strobe_n_in,
	input  wire logic                       burst_step_n_in,
	input  wire logic                       burst_linear_in,
	// Write controls
	input  wire logic                       global_write_n_in,
	input  wire logic                       byte_write_gate_n_in,
	input  wire logic [LANES-1:0]           byte_lane_sel_n_in,
	input  wire logic                       output_gate_n_in,
	// Address and data pins
	input  wire logic [ADDR_W-1:0]          addr_in,
	input  wire logic [LANES*9-1:0]         data_pin_in,
	output logic      [LANES*9-1:0]         data_pin_out,
	output logic                            data_pin_oe_out,
	// Core side
	output logic                            core_wr_valid_out,
	input  wire logic                       core_wr_ready_in,
	output logic      [ADDR_W-1:0]          core_wr_addr_out,
	output logic      [LANES-1:0]           core_wr_lane_out,
	output logic      [LANES*9-1:0]         core_wr_data_out,
	output logic                            core_wr_stall_out,
	output logic      [ADDR_W-1:0]          core_rd_addr_out,
	output logic                            core_rd_en_out,
	input  wire logic [LANES*9-1:0]         core_rd_data_in,
	output logic                            asleep_out,
	output logic      [2:0]                 cycle_out
);
	localparam int BW = ADDR_W + LANES + LANES * 9;

	sbs_pkg::sbs_state_type state_q;
	sbs_pkg::sbs_cycle_type cyc;
	logic [1:0]        sleep_sync_q;
	logic [1:0]        mode_sync_q;
	logic [1:0]        sleep_cnt_q;
	logic [ADDR_W-1:0] base_q;
	logic [1:0]        start_q;
	logic [1:0]        cnt_q;
	logic              drive_q;
	logic [LANES*9-1:0] rd_data_q;
	logic              selected;
	logic              deselect;
	logic              begin_ext;
	logic              proc_open;
	logic              is_write;
	logic [LANES-1:0]  lanes;
	logic              buf_ready;
	logic              wr_now;
	logic [ADDR_W-1:0] cur_addr;
	logic [1:0]        next_cnt;

	// Burst order step
	function automatic logic [1:0] burst_next(input logic [1:0] start, input logic [1:0] cnt, input logic lin);
		logic [1:0] k;
		k = (cnt ^ start) + 2'h1;
		burst_next = lin ? (cnt + 2'h1) : (start ^ k);
	endfunction

	// Asynchronous inputs pass two flip-flops
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			sleep_sync_q <= 2'h0;
			mode_sync_q  <= 2'h0;
		end
		else
		begin
			sleep_sync_q <= {sleep_sync_q[0], sleep_request_in};
			mode_sync_q  <= {mode_sync_q[0], burst_linear_in};
		end
	end

	always_comb
	begin
		if (THREE_SELECT)
			selected = !chip_select_primary_n_in && chip_select_positive_in && !chip_select_secondary_n_in;
		else
			selected = !chip_select_primary_n_in;
		lanes = {LANES{!global_write_n_in}} |
			({LANES{!byte_write_gate_n_in}} & ~byte_lane_sel_n_in);
		is_write = |lanes;
		proc_open = !proc_addr_strobe_n_in && !chip_select_primary_n_in;
		deselect = !selected && (proc_open || !ctrl_addr_strobe_n_in);
		begin_ext = selected && (proc_open || !ctrl_addr_strobe_n_in);
		if (state_q == sbs_pkg::SBS_ST_ASLEEP || sleep_sync_q[1])
			cyc = sbs_pkg::SBS_CYC_SLEEP;
		else if (deselect)
			cyc = sbs_pkg::SBS_CYC_DESELECT;
		else if (begin_ext)
			cyc = sbs_pkg::SBS_CYC_BEGIN;
		else if (state_q == sbs_pkg::SBS_ST_IDLE)
			cyc = sbs_pkg::SBS_CYC_DESELECT;
		else if (!burst_step_n_in)
			cyc = sbs_pkg::SBS_CYC_CONTINUE;
		else
			cyc = sbs_pkg::SBS_CYC_SUSPEND;
	end

	assign next_cnt = burst_next(start_q, cnt_q, mode_sync_q[1]);
	assign cur_addr = (cyc == sbs_pkg::SBS_CYC_CONTINUE) ? {base_q[ADDR_W-1:2], next_cnt} : {base_q[ADDR_W-1:2], cnt_q};
	// Write taken on continue and suspend cycles, or on controller-begin edges; processor-begin defers it
	assign wr_now = is_write && !(cyc == sbs_pkg::SBS_CYC_SLEEP) && !(cyc == sbs_pkg::SBS_CYC_DESELECT)
		&& !(cyc == sbs_pkg::SBS_CYC_BEGIN && proc_open) && !(cyc == sbs_pkg::SBS_CYC_BEGIN && !is_write);

	// Address, burst counter and state
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_q <= sbs_pkg::SBS_ST_IDLE;
			base_q  <= '0;
			start_q <= 2'h0;
			cnt_q   <= 2'h0;
		end
		else
		begin
			case (cyc)
				sbs_pkg::SBS_CYC_SLEEP:
					state_q <= sleep_sync_q[1] ? sbs_pkg::SBS_ST_ASLEEP : sbs_pkg::SBS_ST_IDLE;
				sbs_pkg::SBS_CYC_DESELECT:
					state_q <= sbs_pkg::SBS_ST_IDLE;
				sbs_pkg::SBS_CYC_BEGIN:
				begin
					base_q  <= addr_in;
					start_q <= addr_in[1:0];
					cnt_q   <= addr_in[1:0];
					state_q <= (is_write && !proc_open) ? sbs_pkg::SBS_ST_WRITE : sbs_pkg::SBS_ST_READ;
				end
				sbs_pkg::SBS_CYC_CONTINUE:
				begin
					cnt_q   <= next_cnt;
					state_q <= is_write ? sbs_pkg::SBS_ST_WRITE : sbs_pkg::SBS_ST_READ;
				end
				sbs_pkg::SBS_CYC_SUSPEND:
					state_q <= is_write ? sbs_pkg::SBS_ST_WRITE : sbs_pkg::SBS_ST_READ;
				default:
					state_q <= sbs_pkg::SBS_ST_IDLE;
			endcase
		end
	end

	// Sleep entry counter, bounded at two cycles
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			sleep_cnt_q <= 2'h0;
		else if (!sleep_sync_q[1])
			sleep_cnt_q <= 2'h0;
		else if (sleep_cnt_q != 2'(`SBS_SLEEP_CYCLES))
			sleep_cnt_q <= sleep_cnt_q + 2'h1;
	end
	assign asleep_out = (state_q == sbs_pkg::SBS_ST_ASLEEP);

	// Read data register; drives only after the first read cycle
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			drive_q   <= 1'b0;
			rd_data_q <= '0;
		end
		else
		begin
			drive_q   <= !is_write && state_q == sbs_pkg::SBS_ST_READ &&
				(cyc == sbs_pkg::SBS_CYC_CONTINUE || cyc == sbs_pkg::SBS_CYC_SUSPEND);
			rd_data_q <= core_rd_data_in;
		end
	end
	// Suspended reads fetch the current word again so the held pins keep it
	assign core_rd_en_out  = (cyc == sbs_pkg::SBS_CYC_BEGIN && (!is_write || proc_open)) ||
		(state_q == sbs_pkg::SBS_ST_READ && !is_write &&
		(cyc == sbs_pkg::SBS_CYC_CONTINUE || cyc == sbs_pkg::SBS_CYC_SUSPEND));
	assign core_rd_addr_out = (cyc == sbs_pkg::SBS_CYC_BEGIN) ? addr_in : cur_addr;
	assign data_pin_out     = rd_data_q;
	assign data_pin_oe_out  = drive_q && !output_gate_n_in;
	assign cycle_out        = 3'(cyc);

	// Write stream through the two-entry buffer; lane i covers bits 9i+8:9i
	sbs_buf2 #(
		.WIDTH (BW)
	) u_wbuf (
		.clk_in        (clk_in),
		.nrst_in       (nrst_in),
		.in_valid_in   (wr_now),
		.in_ready_out  (buf_ready),
		.in_data_in    ({(cyc == sbs_pkg::SBS_CYC_BEGIN) ? addr_in : cur_addr, lanes, data_pin_in}),
		.out_valid_out (core_wr_valid_out),
		.out_ready_in  (core_wr_ready_in),
		.out_data_out  ({core_wr_addr_out, core_wr_lane_out, core_wr_data_out})
	);
	assign core_wr_stall_out = !buf_ready;

	sequence sleep_seen_s;
		sleep_sync_q[1] && state_q != sbs_pkg::SBS_ST_ASLEEP;
	endsequence

	sleep_entry_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sleep_seen_s |=> ##[0:1] asleep_out) else $error("sleep not entered in time");
	pins_sleep_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		asleep_out |-> !data_pin_oe_out) else $error("pins driven asleep");
	oe_gate_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		output_gate_n_in |-> !data_pin_oe_out) else $error("pins driven with gate high");
	write_float_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		data_pin_oe_out |-> $past(!is_write)) else $error("pins driven after write");
	deselect_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(deselect && !sleep_sync_q[1] && !asleep_out) |=> state_q == sbs_pkg::SBS_ST_IDLE && !data_pin_oe_out)
		else $error("deselect not idle");
	begin_addr_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		cyc == sbs_pkg::SBS_CYC_BEGIN |=> base_q == $past(addr_in)) else $error("begin address lost");
	proc_defer_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(cyc == sbs_pkg::SBS_CYC_BEGIN && proc_open) |-> !wr_now) else $error("write on processor begin");
	burst_lin_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(cyc == sbs_pkg::SBS_CYC_CONTINUE && mode_sync_q[1]) |=> cnt_q == $past(cnt_q) + 2'h1)
		else $error("linear burst step wrong");
	suspend_hold_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		cyc == sbs_pkg::SBS_CYC_SUSPEND |=> $stable(cnt_q)) else $error("suspend moved address");
	lane_map_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(global_write_n_in && !byte_write_gate_n_in && !byte_lane_sel_n_in[0]) |-> lanes[0])
		else $error("lane a not written");
	psel_ignore_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(chip_select_primary_n_in && ctrl_addr_strobe_n_in) |-> cyc != sbs_pkg::SBS_CYC_BEGIN)
		else $error("processor strobe not ignored");
	sleep_count_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		sleep_cnt_q == 2'(`SBS_SLEEP_CYCLES) |-> asleep_out) else $error("sleep count reached while awake");
endmodule // sbs_cycle_decode

//--- sbs_regs.svh
/*
 Timing counts and field positions for the burst SRAM cycle decoder.
 Assumes one 40 MHz clock; included by bare name.
*/
// How it works
// - Unselected edges with an address strobe use no address, float pins
// - Write when global write or gated lanes
// - Drive pins only on later read cycles
// - Output gate acts combinationally on drivers
// - Three-select variant needs all selects active
// - Single-select variant uses primary select only
// - Lane a writes bits 7:0, parity 0
// - Lane b writes 15:8, parity 1; nine-bit groups
// - Two-bit burst counter, interleaved or linear order
// - Processor strobe ignored while primary select high
// - Processor-opened access writes on following edge
// - Sleep within two cycles; pins float, contents kept
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_CLK_PERIOD_NS 25
`define SBS_SLEEP_TIME_CYC 2
`define SBS_SLEEP_CYCLES ((`SBS_SLEEP_TIME_CYC * `SBS_CLK_PERIOD_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS)
`define SBS_LANE_BITS 9
`define SBS_BURST_BITS 2
`endif

//--- sbs_pkg.sv
/*
 Types for the burst SRAM cycle decoder.
 Assumes sbs_regs.svh is compiled with it.
*/
package sbs_pkg;
	typedef enum logic [2:0] {
		SBS_CYC_DESELECT,
		SBS_CYC_BEGIN,
		SBS_CYC_CONTINUE,
		SBS_CYC_SUSPEND,
		SBS_CYC_SLEEP
	} sbs_cycle_type;
	typedef enum logic [1:0] {
		SBS_ST_IDLE,
		SBS_ST_READ,
		SBS_ST_WRITE,
		SBS_ST_ASLEEP
	} sbs_state_type;
endpackage

//--- sbs_buf2.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module sbs_buf2 #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// Fill side
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	// Drain side
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic      [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem_q [2];
	logic             rd_q;
	logic             wr_q;
	logic [1:0]       cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_out  = (cnt_q != 2'h2);
	assign out_valid_out = (cnt_q != 2'h0);
	assign out_data_out  = mem_q[rd_q];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	// Storage
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem_q[wr_q] <= in_data_in;
	end

	// Pointers and fill count
	always_ff @(posedge clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rd_q  <= 1'b0;
			wr_q  <= 1'b0;
			cnt_q <= 2'h0;
		end
		else
		begin
			if (push)
				wr_q <= ~wr_q;
			if (pop)
				rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // sbs_buf2

//--- sbs_core_model.sv
/*
 Behavioural core array facing the cycle decoder's core side.
 Assumes one clock; stall_in comes from the bench's random source.
*/
`timescale 1ns/1ps
module sbs_core_model #(
	parameter int LANES  = 2,
	parameter int ADDR_W = 19
) (
	// Clock and back-pressure
	input  wire logic                 clk_in,
	input  wire logic                 stall_in,
	// Write stream
	input  wire logic                 wr_valid_in,
	output logic                      wr_ready_out,
	input  wire logic [ADDR_W-1:0]    wr_addr_in,
	input  wire logic [LANES-1:0]     wr_lane_in,
	input  wire logic [LANES*9-1:0]   wr_data_in,
	// Read port
	input  wire logic [ADDR_W-1:0]    rd_addr_in,
	input  wire logic                 rd_en_in,
	output logic      [LANES*9-1:0]   rd_data_out
);
	logic [LANES*9-1:0] mem_q [16];
	initial
	begin
		foreach (mem_q[i]) mem_q[i] = '0;
	end
	assign wr_ready_out = !stall_in;
	// Unread cycles show the inverse so stale data never passes
	assign rd_data_out = rd_en_in ? mem_q[rd_addr_in[3:0]] : ~mem_q[rd_addr_in[3:0]];
	always @(posedge clk_in)
		if (wr_valid_in && wr_ready_out)
			for (int i = 0; i < LANES; i++)
				if (wr_lane_in[i]) mem_q[wr_addr_in[3:0]][9*i+:9] <= wr_data_in[9*i+:9];
endmodule // sbs_core_model

//--- tb_top.sv
/*
 Self-checking bench for the cycle decoder in its two-lane form.
 Assumes the core model answers reads in the same cycle.
*/
`timescale 1ns/1ps
module tb_top;
	logic clk_in = 0, nrst_in = 0, sp = 0, cp_n = 1, cpos = 1, cs_n = 0, ps_n = 1, cst_n = 0;
	logic step_n = 1, lin = 0, gw_n = 1, bwe_n = 1, og_n = 0, stall = 0, hold = 0;
	logic [1:0]  lane_n = 2'h3, wlane;
	logic [18:0] addr = '0, wa, ra;
	logic [17:0] din = '0, dout, wd, rd;
	logic oe, wv, wr, rden, asleep, full;
	logic [2:0] cyc_k, cyc1_k;
	logic [31:0] rs = 32'hC58E34EB;
	logic [17:0] em [16];
	logic [38:0] q [$];
	logic [38:0] e;
	int err_total = 0, comparisons = 0;
	always #12.5 clk_in = ~clk_in;
	sbs_cycle_decode #(.LANES(2), .ADDR_W(19), .THREE_SELECT(1'b1)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in),
		.sleep_request_in(sp), .chip_select_primary_n_in(cp_n), .chip_select_positive_in(cpos),
		.chip_select_secondary_n_in(cs_n), .proc_addr_strobe_n_in(ps_n), .ctrl_addr_strobe_n_in(cst_n),
		.burst_step_n_in(step_n), .burst_linear_in(lin), .global_write_n_in(gw_n),
		.byte_write_gate_n_in(bwe_n), .byte_lane_sel_n_in(lane_n), .output_gate_n_in(og_n), .addr_in(addr),
		.data_pin_in(din), .data_pin_out(dout), .data_pin_oe_out(oe), .core_wr_valid_out(wv),
		.core_wr_ready_in(wr), .core_wr_addr_out(wa), .core_wr_lane_out(wlane), .core_wr_data_out(wd),
		.core_wr_stall_out(full), .core_rd_addr_out(ra), .core_rd_en_out(rden), .core_rd_data_in(rd),
		.asleep_out(asleep), .cycle_out(cyc_k));
	sbs_core_model #(.LANES(2), .ADDR_W(19)) core_u (.clk_in(clk_in), .stall_in(stall), .wr_valid_in(wv),
		.wr_ready_out(wr), .wr_addr_in(wa), .wr_lane_in(wlane), .wr_data_in(wd), .rd_addr_in(ra),
		.rd_en_in(rden), .rd_data_out(rd));
	// Single-select variant watched on cycle kind only
	sbs_cycle_decode #(.LANES(2), .ADDR_W(19), .THREE_SELECT(1'b0)) dut_single_u (.clk_in(clk_in),
		.nrst_in(nrst_in), .sleep_request_in(sp), .chip_select_primary_n_in(cp_n), .chip_select_positive_in(cpos),
		.chip_select_secondary_n_in(cs_n), .proc_addr_strobe_n_in(ps_n), .ctrl_addr_strobe_n_in(cst_n),
		.burst_step_n_in(step_n), .burst_linear_in(lin), .global_write_n_in(gw_n),
		.byte_write_gate_n_in(bwe_n), .byte_lane_sel_n_in(lane_n), .output_gate_n_in(og_n), .addr_in(addr),
		.data_pin_in(din), .data_pin_out(), .data_pin_oe_out(), .core_wr_valid_out(),
		.core_wr_ready_in(1'b1), .core_wr_addr_out(), .core_wr_lane_out(), .core_wr_data_out(),
		.core_wr_stall_out(), .core_rd_addr_out(), .core_rd_en_out(), .core_rd_data_in(rd),
		.asleep_out(), .cycle_out(cyc1_k));
	function automatic logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task automatic chk(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
		begin
			err_total++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// sel = primary_n, positive, secondary_n; sb = proc_n, ctrl_n; wv4 = global_n, gate_n, lanes_n
	task automatic cyc(input logic [2:0] sel, input logic [1:0] sb, input logic sn, input logic [3:0] wv4,
		input logic [18:0] a, input logic [17:0] d, input logic [2:0] ek);
		@(posedge clk_in);
		{cp_n, cpos, cs_n} <= sel;
		{ps_n, cst_n} <= sb;
		step_n <= sn;
		{gw_n, bwe_n, lane_n} <= wv4;
		addr <= a;
		din <= d;
		@(negedge clk_in);
		chk(cyc_k === ek, "cycle kind");
	endtask
	task automatic note_wr(input logic [18:0] a, input logic [3:0] wv4, input logic [17:0] d);
		logic [1:0] m;
		m = !wv4[3] ? 2'h3 : (!wv4[2] ? ~wv4[1:0] : 2'h0);
		for (int i = 0; i < 2; i++)
			if (m[i]) em[a[3:0]][9*i+:9] = d[9*i+:9];
		if (m != 2'h0) q.push_back({a, m, d});
		chk(oe === 1'b0, "pins driven in write");
	endtask
	task automatic idle(input int n);
		repeat (n) cyc(3'b110, 2'b10, 1'b1, 4'hF, '0, '0, 3'h0);
	endtask
	always @(posedge clk_in)
		stall <= hold | 1'(xs());
	always @(posedge clk_in)
		if (nrst_in && wv && wr)
		begin
			e = (q.size() > 0) ? q.pop_front() : '0;
			chk(wa === e[38:20] && wlane === e[19:18], "write address or lanes");
			chk((wd & {{9{e[19]}}, {9{e[18]}}}) === (e[17:0] & {{9{e[19]}}, {9{e[18]}}}), "write data");
		end
	initial
	begin
		#(25 * 5000);
		err_total++;
		report_and_stop();
	end
	initial
	begin
		logic [17:0] d;
		logic [3:0] w4;
		foreach (em[i]) em[i] = '0;
		repeat (8) @(posedge clk_in);
		nrst_in <= 1'b1;
		idle(2);
		cyc(3'b110, 2'b00, 1'b1, 4'hF, '0, '0, 3'h0);
		cyc(3'b000, 2'b10, 1'b1, 4'hF, '0, '0, 3'h0);
		chk(cyc1_k === 3'h1, "single select did not begin");
		cyc(3'b011, 2'b00, 1'b1, 4'hF, '0, '0, 3'h0);
		chk(cyc1_k === 3'h1, "single select did not begin");
		for (int k = 0; k < 6; k++)
		begin
			d = 18'(xs());
			w4 = (k < 3) ? 4'h7 : {2'b10, k[1:0] == 2'd3 ? 2'b10 : 2'b01};
			while (full) idle(1);
			cyc(3'b010, 2'b10, 1'b1, w4, 19'(k % 3), d, 3'h1);
			note_wr(19'(k % 3), w4, d);
			idle(1);
		end
		d = 18'(xs());
		while (full) idle(1);
		cyc(3'b010, 2'b01, 1'b0, 4'h0, 19'h3, ~d, 3'h1);
		cyc(3'b010, 2'b11, 1'b1, 4'h7, 19'h3, d, 3'h3);
		note_wr(19'h3, 4'h7, d);
		idle(1);
		for (int n = 0; n < 50 && q.size() > 0; n++) idle(1);
		chk(q.size() === 0, "writes not delivered");
		hold <= 1'b1;
		for (int j = 0; j < 2; j++)
		begin
			d = 18'(xs());
			cyc(3'b010, 2'b10, 1'b1, 4'h7, 19'(4 + j), d, 3'h1);
			note_wr(19'(4 + j), 4'h7, d);
			idle(1);
		end
		chk(full === 1'b1, "full buffer not flagged");
		hold <= 1'b0;
		for (int n = 0; n < 50 && q.size() > 0; n++) idle(1);
		chk(q.size() === 0 && full === 1'b0, "stalled writes not delivered");
		for (int m = 0; m < 2; m++)
		begin
			lin <= m[0];
			idle(4);
			cyc(3'b010, 2'b10, 1'b1, 4'hF, 19'h1, '0, 3'h1);
			cyc(3'b110, 2'b01, 1'b0, 4'hF, 19'h1, '0, 3'h2);
			chk(oe === 1'b0, "pins driven on first read cycle");
			cyc(3'b010, 2'b11, 1'b1, 4'hF, 19'h1, '0, 3'h3);
			chk(oe === 1'b1 && dout === em[m ? 2 : 0], "burst read data");
			og_n <= 1'b1;
			#1;
			chk(oe === 1'b0, "output gate not combinational");
			idle(1);
			og_n <= 1'b0;
			#1;
			chk(oe === 1'b1 && dout === em[m ? 2 : 0], "suspend read data");
			idle(1);
			chk(oe === 1'b0, "pins driven after deselect");
		end
		sp <= 1'b1;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		chk(asleep === 1'b1 && cyc_k === 3'h4 && oe === 1'b0, "sleep entry");
		sp <= 1'b0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		chk(cyc_k === 3'h4, "sleep left early");
		idle(6);
		chk(asleep === 1'b0, "sleep exit");
		report_and_stop();
	end
endmodule // tb_top
